/* File: hdl/fdpc_regs.sv */
// fdpc_regs: data-flash protection, command object array, option byte and reserved registers
// assumes a classic wishbone master and a command engine that pulses cmd_done_i
// Functional notes
// - protection writes only grow size while closed; open bit only goes one to zero
// - open bit set means size ignored, data flash unprotected
// - protection register loaded at reset from configuration byte
// - double-bit fault on that fetch gives full protection
// - program or erase inside protected area rejected, sets violation flag
// - data flash block erase refused if any sector protected
// - bit seven is open control, zero enables protection
// - size field protects (value plus one) times 256 bytes from base
// - command object is six 16-bit words selected by 3-bit index
// - byte-wide reads and writes to high and low halves
// - fields locked from launch until completion; flag then returns to one
// - command results are written into the array and readable after completion
// - indices six and seven ignore writes and read zero
// - word zero holds command code and address 17:16, word one address 15:0
// - words two to five hold data words zero to three
// - reserved test registers read zero and ignore writes
// - option register is read-only
// - option register loaded at reset from configuration byte
// - double-bit fault on that fetch sets all option bits
// - while flag is zero all bus writes to the command object ignored
`timescale 1ns/1ps
`default_nettype none
module fdpc_regs (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic cfg_rd_req_o,
    output logic [17:0] cfg_rd_addr_o,
    input wire logic cfg_rd_ack_i,
    input wire logic [7:0] cfg_rd_data_i,
    input wire logic cfg_rd_dbe_i,
    output logic cfg_ready_o,
    output logic cmd_start_o,
    output logic [7:0] cmd_code_o,
    output logic [17:0] cmd_addr_o,
    input wire logic cmd_done_i,
    input wire logic cmd_res_we_i,
    input wire logic [2:0] cmd_res_idx_i,
    input wire logic [15:0] cmd_res_data_i,
    output logic [7:0] prot_o,
    output logic [7:0] option_o
);
    import fdpc_pkg::*;

    typedef enum logic [3:0] {
        LD_DPROT = 4'b0001,
        LD_OPT = 4'b0010,
        LD_RUN = 4'b0100,
        LD_IDLE = 4'b1000
    } fdpc_ld_state_t;

    typedef struct packed {
        fdpc_ld_state_t ld;
        logic ack;
        logic [31:0] rdat;
        logic [7:0] prot;
        logic [7:0] opt;
        logic [2:0] idx;
        logic command_complete_flag;
        logic viol;
        logic start;
        logic [CO_WORDS*16-1:0] obj;
    } fdpc_state_t;

    fdpc_state_t st_ff, nxt_st;

    logic dp_req, dp_done, op_req, op_done, viol;
    logic [17:0] dp_addr, op_addr;
    logic [7:0] dp_val, op_val;
    logic [7:0] cmd_code;
    logic [17:0] cmd_addr;
    logic req, wr, rd;

    assign cmd_code = st_ff.obj[15:8];
    assign cmd_addr = {st_ff.obj[1:0], st_ff.obj[31:16]};

    fdpc_cfg_loader #(
        .ADDR(CFG_DPROT_ADDR),
        .FAULT_VALUE(DP_FAULT_VALUE)
    ) u_ld_dprot (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(st_ff.ld == LD_DPROT && !dp_req && !dp_done),
        .gnt_i(st_ff.ld == LD_DPROT),
        .rd_ack_i(cfg_rd_ack_i),
        .rd_data_i(cfg_rd_data_i),
        .rd_dbe_i(cfg_rd_dbe_i),
        .req_o(dp_req),
        .addr_o(dp_addr),
        .done_o(dp_done),
        .value_o(dp_val)
    );

    fdpc_cfg_loader #(
        .ADDR(CFG_OPT_ADDR),
        .FAULT_VALUE(OPT_FAULT_VALUE)
    ) u_ld_opt (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .start_i(st_ff.ld == LD_OPT && !op_req && !op_done),
        .gnt_i(st_ff.ld == LD_OPT),
        .rd_ack_i(cfg_rd_ack_i),
        .rd_data_i(cfg_rd_data_i),
        .rd_dbe_i(cfg_rd_dbe_i),
        .req_o(op_req),
        .addr_o(op_addr),
        .done_o(op_done),
        .value_o(op_val)
    );

    fdpc_prot_check u_chk (
        .prot_i(st_ff.prot),
        .cmd_i(cmd_code),
        .addr_i(cmd_addr),
        .viol_o(viol)
    );

    // one ack per request, answered one cycle after the strobe, then dropped
    assign req = wb_cyc_i && wb_stb_i && !st_ff.ack;
    assign wr = req && wb_we_i;
    assign rd = req && !wb_we_i;

    always_comb begin
        logic [7:0] wdp;
        logic [15:0] cur;
        int base;
        wdp = 8'h00;
        cur = 16'h0000;
        base = 0;
        nxt_st = st_ff;
        nxt_st.ack = req;
        nxt_st.start = 1'b0;

        // reset-time configuration sequence, one fetch at a time
        case (st_ff.ld)
            LD_DPROT: begin
                if (dp_done) begin
                    nxt_st.prot = {dp_val[7], 3'h0, dp_val[3:0]};
                    nxt_st.ld = LD_OPT;
                end
            end
            LD_OPT: begin
                if (op_done) begin
                    nxt_st.opt = op_val;
                    nxt_st.ld = LD_IDLE;
                end
            end
            LD_RUN: begin
                if (cmd_done_i) begin
                    nxt_st.command_complete_flag = 1'b1;
                    nxt_st.ld = LD_IDLE;
                end
            end
            LD_IDLE: begin
            end
            default: begin
                nxt_st.ld = LD_DPROT;
            end
        endcase

        // engine results land in the array while the command runs
        if (st_ff.ld == LD_RUN && cmd_res_we_i && cmd_res_idx_i <= CO_IDX_LAST) begin
            base = 16 * int'(cmd_res_idx_i);
            nxt_st.obj[base +: 16] = cmd_res_data_i;
        end

        if (wr && st_ff.ld == LD_IDLE) begin
            if (wb_adr_i == OFF_DPROT && wb_sel_i[0]) begin
                wdp = wb_dat_i[7:0];
                // open may only close; size may only grow while closed
                if (st_ff.prot[DP_OPEN_BIT] && wdp[DP_OPEN_BIT]) begin
                    nxt_st.prot = {1'b1, 3'h0, wdp[3:0]};
                end else if (st_ff.prot[DP_OPEN_BIT]) begin
                    nxt_st.prot = {1'b0, 3'h0, wdp[3:0]};
                end else if (!wdp[DP_OPEN_BIT] && wdp[3:0] > st_ff.prot[3:0]) begin
                    nxt_st.prot = {1'b0, 3'h0, wdp[3:0]};
                end
            end else if (wb_adr_i == OFF_CIDX && wb_sel_i[0]) begin
                nxt_st.idx = wb_dat_i[2:0];
            end else if (wb_adr_i == OFF_CWORD && st_ff.command_complete_flag) begin
                if (st_ff.idx <= CO_IDX_LAST) begin
                    base = 16 * int'(st_ff.idx);
                    if (wb_sel_i[0]) begin
                        nxt_st.obj[base +: 8] = wb_dat_i[7:0];
                    end
                    if (wb_sel_i[1]) begin
                        nxt_st.obj[base + 8 +: 8] = wb_dat_i[15:8];
                    end
                end
            end else if (wb_adr_i == OFF_STAT && wb_sel_i[0]) begin
                if (wb_dat_i[ST_VIOL_BIT]) begin
                    nxt_st.viol = 1'b0;
                end
                if (wb_dat_i[ST_COMMAND_COMPLETE_FLAG_BIT] && st_ff.command_complete_flag) begin
                    // launch: refused commands never leave the flag low
                    if (viol) begin
                        nxt_st.viol = 1'b1;
                    end else begin
                        nxt_st.command_complete_flag = 1'b0;
                        nxt_st.start = 1'b1;
                        nxt_st.ld = LD_RUN;
                    end
                end
            end else if (wb_adr_i == OFF_CFG && wb_sel_i[0] && wb_dat_i[CFG_RELOAD_BIT]) begin
                nxt_st.ld = LD_DPROT; // replays the reset-time fetch of both bytes
            end
        end

        if (rd) begin
            nxt_st.rdat = 32'h0;
            if (wb_adr_i == OFF_DPROT) begin
                nxt_st.rdat[7:0] = st_ff.prot;
            end else if (wb_adr_i == OFF_CIDX) begin
                nxt_st.rdat[2:0] = st_ff.idx;
            end else if (wb_adr_i == OFF_CWORD) begin
                if (st_ff.idx <= CO_IDX_LAST) begin
                    base = 16 * int'(st_ff.idx);
                    cur = st_ff.obj[base +: 16];
                end
                nxt_st.rdat[15:0] = cur & {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
            end else if (wb_adr_i == OFF_STAT) begin
                nxt_st.rdat[ST_COMMAND_COMPLETE_FLAG_BIT] = st_ff.command_complete_flag;
                nxt_st.rdat[ST_VIOL_BIT] = st_ff.viol;
            end else if (wb_adr_i == OFF_OPT) begin
                nxt_st.rdat[7:0] = st_ff.opt;
            end else if (wb_adr_i == OFF_CFG) begin
                nxt_st.rdat[1] = (st_ff.ld != LD_DPROT && st_ff.ld != LD_OPT);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
            st_ff.ld <= LD_DPROT;
            st_ff.command_complete_flag <= 1'b1;
            st_ff.prot <= DP_FAULT_VALUE;
            st_ff.opt <= OPT_FAULT_VALUE;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign wb_ack_o = st_ff.ack;
    assign wb_dat_o = st_ff.rdat;
    assign cfg_rd_req_o = dp_req || op_req;
    assign cfg_rd_addr_o = op_req ? op_addr : dp_addr;
    assign cfg_ready_o = (st_ff.ld == LD_IDLE) || (st_ff.ld == LD_RUN);
    assign cmd_start_o = st_ff.start;
    assign cmd_code_o = cmd_code;
    assign cmd_addr_o = cmd_addr;
    assign prot_o = st_ff.prot;
    assign option_o = st_ff.opt;

    // protection register and reset-time loading
    a_prot_only_grows: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.ld == LD_IDLE && !$past(st_ff.prot[7]) && $past(st_ff.ld) == LD_IDLE)
        |-> (!st_ff.prot[7] && st_ff.prot[3:0] >= $past(st_ff.prot[3:0])))
        else $error("protection was reduced");
    a_prot_rsvd_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.prot[6:4] == 3'h0) else $error("protection bits six to four set");
    a_open_no_viol: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.prot[DP_OPEN_BIT] |-> !viol) else $error("open protection refused a command");
    // a carry lost in the span sum would leave the whole data flash open at full size
    a_top_sector_guarded: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_ff.prot[DP_OPEN_BIT] && st_ff.prot[3:0] == DP_SIZE_FULL
         && cmd_code == CMD_PROG_DF && cmd_addr == DF_END) |-> viol)
        else $error("top data flash byte unguarded at full size");
    a_erase_refused: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_ff.prot[DP_OPEN_BIT] && cmd_code == CMD_ERASE_BLOCK
         && cmd_addr >= DF_BASE && cmd_addr <= DF_END) |-> viol)
        else $error("block erase allowed under protection");
    a_fault_prot: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.ld == LD_DPROT && dp_done && dp_val == DP_FAULT_VALUE)
        |=> st_ff.prot == DP_FAULT_VALUE) else $error("fault value not applied");
    a_opt_loaded: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.ld == LD_OPT && op_done) |=> (st_ff.opt == $past(op_val)
         && st_ff.ld == LD_IDLE)) else $error("option byte not loaded");

    // command object and launch handshake
    a_obj_locked: assert property (@(posedge clk_i) disable iff (rst_i)
        (!st_ff.command_complete_flag && !cmd_res_we_i) |=> st_ff.obj == $past(st_ff.obj))
        else $error("command object changed while locked");
    a_obj_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == OFF_CWORD && !st_ff.command_complete_flag && !cmd_res_we_i)
        |=> $stable(st_ff.obj)) else $error("write taken while busy");
    a_unimpl_write_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == OFF_CWORD && st_ff.idx > CO_IDX_LAST && !cmd_res_we_i)
        |=> $stable(st_ff.obj)) else $error("unimplemented index written");
    a_idx_written: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && st_ff.ld == LD_IDLE && wb_adr_i == OFF_CIDX && wb_sel_i[0])
        |=> st_ff.idx == $past(wb_dat_i[2:0])) else $error("index not written");
    a_launch_clears: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.start |-> (!st_ff.command_complete_flag && $past(st_ff.command_complete_flag)))
        else $error("start without flag falling");
    a_start_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
        st_ff.start |=> !st_ff.start) else $error("start held two cycles");
    // the engine owns the array until done; bus reads are not blocked and can see a partial result
    a_flag_held_low: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.ld == LD_RUN && !cmd_done_i) |=> !st_ff.command_complete_flag) else $error("flag rose early");
    a_flag_returns: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.ld == LD_RUN && cmd_done_i) |=> (st_ff.command_complete_flag && st_ff.ld == LD_IDLE))
        else $error("flag not returned on completion");
    a_viol_refuses: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && wb_adr_i == OFF_STAT && wb_sel_i[0] && wb_dat_i[7] && st_ff.command_complete_flag
         && st_ff.ld == LD_IDLE && viol) |=> (st_ff.viol && st_ff.command_complete_flag && !st_ff.start))
        else $error("protected command launched");
    a_viol_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (wr && st_ff.ld == LD_IDLE && wb_adr_i == OFF_STAT && wb_sel_i[0]
         && wb_dat_i[ST_VIOL_BIT] && !wb_dat_i[ST_COMMAND_COMPLETE_FLAG_BIT]) |=> !st_ff.viol)
        else $error("violation flag not cleared");

    // bus side reads
    a_unimpl_reads_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && wb_adr_i == OFF_CWORD && st_ff.idx > CO_IDX_LAST) |=> wb_dat_o == 32'h0)
        else $error("unimplemented index read nonzero");
    a_rsvd_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
        (rd && wb_adr_i >= OFF_RSV1 && wb_adr_i <= OFF_RSV4) |=> wb_dat_o == 32'h0)
        else $error("reserved register nonzero");
    a_opt_stable: assert property (@(posedge clk_i) disable iff (rst_i)
        (st_ff.ld == LD_IDLE) |=> $stable(st_ff.opt) || $past(st_ff.ld) != LD_IDLE)
        else $error("option byte changed by software");
    a_ack_one_cycle: assert property (@(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");

    c_launch: cover property (@(posedge clk_i) disable iff (rst_i) st_ff.start);
    c_complete: cover property (@(posedge clk_i) disable iff (rst_i)
        st_ff.ld == LD_RUN && cmd_done_i);
    c_violation: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st_ff.viol));
    c_fault_load: cover property (@(posedge clk_i) disable iff (rst_i)
        dp_done && dp_val == DP_FAULT_VALUE);
    c_reload: cover property (@(posedge clk_i) disable iff (rst_i)
        st_ff.ld == LD_IDLE ##1 st_ff.ld == LD_DPROT);
endmodule : fdpc_regs
`default_nettype wire

/* File: include/fdpc_pkg.sv */
// fdpc_pkg: shared constants for the flash protection / command object register block
// assumes a 32-bit classic wishbone slave with word-aligned registers
package fdpc_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_DPROT = 8'h00;
    localparam logic [7:0] OFF_CIDX = 8'h04;
    localparam logic [7:0] OFF_CWORD = 8'h08;
    localparam logic [7:0] OFF_STAT = 8'h0c;
    localparam logic [7:0] OFF_OPT = 8'h10;
    localparam logic [7:0] OFF_RSV1 = 8'h14;
    localparam logic [7:0] OFF_RSV4 = 8'h20;
    localparam logic [7:0] OFF_CFG = 8'h24;
    // protection register fields
    localparam int DP_OPEN_BIT = 7;
    localparam logic [3:0] DP_SIZE_FULL = 4'hf;
    localparam logic [7:0] DP_FAULT_VALUE = 8'h0f;
    localparam logic [7:0] OPT_FAULT_VALUE = 8'hff;
    // configuration addresses fetched at reset
    localparam logic [17:0] CFG_DPROT_ADDR = 18'h3ff0d;
    localparam logic [17:0] CFG_OPT_ADDR = 18'h3ff0e;
    // data flash window
    localparam logic [17:0] DF_BASE = 18'h04400;
    localparam int DF_SECT_SHIFT = 8;
    localparam logic [17:0] DF_END = 18'h053ff;
    // command object
    localparam int CO_WORDS = 6;
    localparam logic [2:0] CO_IDX_LAST = 3'h5;
    localparam logic [7:0] CMD_ERASE_BLOCK = 8'h09;
    localparam logic [7:0] CMD_PROG_DF = 8'h11;
    localparam logic [7:0] CMD_ERASE_DF_SECT = 8'h12;
    // status bits
    localparam int ST_COMMAND_COMPLETE_FLAG_BIT = 7;
    localparam int ST_VIOL_BIT = 4;
    localparam int CFG_RELOAD_BIT = 0;
endpackage : fdpc_pkg

/* File: hdl/fdpc_cfg_loader.sv */
// fdpc_cfg_loader: fetches one configuration byte at reset, with ecc fault fallback
// assumes the array answers each read with rd_ack_i one or more cycles later
`timescale 1ns/1ps
`default_nettype none
module fdpc_cfg_loader #(
    parameter logic [17:0] ADDR = 18'h0,
    parameter logic [7:0] FAULT_VALUE = 8'hff
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic gnt_i,
    input wire logic rd_ack_i,
    input wire logic [7:0] rd_data_i,
    input wire logic rd_dbe_i,
    output logic req_o,
    output logic [17:0] addr_o,
    output logic done_o,
    output logic [7:0] value_o
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [7:0] value;
    } fdpc_ld_t;
    fdpc_ld_t st_ff, nxt_st;
    always_comb begin
        nxt_st = st_ff;
        nxt_st.done = 1'b0;
        if (start_i) begin
            nxt_st.busy = 1'b1;
        end else if (st_ff.busy && gnt_i && rd_ack_i) begin
            nxt_st.busy = 1'b0;
            nxt_st.done = 1'b1;
            nxt_st.value = rd_dbe_i ? FAULT_VALUE : rd_data_i;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign req_o = st_ff.busy;
    assign addr_o = ADDR;
    assign done_o = st_ff.done;
    assign value_o = st_ff.value;
endmodule : fdpc_cfg_loader
`default_nettype wire

/* File: hdl/fdpc_prot_check.sv */
// fdpc_prot_check: decides whether a launched command may alter the data flash
// assumes code and address come straight from the command object flops
`timescale 1ns/1ps
`default_nettype none
module fdpc_prot_check (
    input wire logic [7:0] prot_i,
    input wire logic [7:0] cmd_i,
    input wire logic [17:0] addr_i,
    output logic viol_o
);
    import fdpc_pkg::*;
    logic in_df;
    logic [17:0] prot_end;
    logic prot_on;
    always_comb begin
        prot_on = !prot_i[DP_OPEN_BIT];
        // protected span is (size + 1) sectors of 256 bytes from the base
        // the extra bit keeps the carry of size fifteen plus one
        prot_end = DF_BASE + {5'h0, {1'b0, prot_i[3:0]} + 5'h01, 8'h00} - 18'h1;
        in_df = (addr_i >= DF_BASE) && (addr_i <= DF_END);
        viol_o = 1'b0;
        if (prot_on && (cmd_i == CMD_PROG_DF || cmd_i == CMD_ERASE_DF_SECT)) begin
            viol_o = in_df && (addr_i <= prot_end);
        end else if (prot_on && cmd_i == CMD_ERASE_BLOCK) begin
            viol_o = in_df;
        end
    end
endmodule : fdpc_prot_check
`default_nettype wire

/* File: testbench/fdpc_regs_bench.sv */
// fdpc_regs_bench: self-checking bench for the protection and command object registers
// assumes fdpc_regs alone, a wishbone master here and the bench standing in for array and engine
`timescale 1ns/1ps
`default_nettype none
module fdpc_regs_bench;
    import fdpc_pkg::*;
    logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0] wb_adr_i, cfg_rd_data_i, cmd_code_o, prot_o, option_o;
    logic [3:0] wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdv;
    logic cfg_rd_req_o, cfg_rd_ack_i, cfg_rd_dbe_i, cfg_ready_o;
    logic cmd_start_o, cmd_done_i, cmd_res_we_i;
    logic [17:0] cfg_rd_addr_o, cmd_addr_o;
    logic [2:0] cmd_res_idx_i;
    logic [15:0] cmd_res_data_i;
    int err_count = 0;
    int checks = 0;
    int starts = 0;
    int cycles = 0;
    logic [15:0] pat [8] = '{16'h1101, 16'h2222, 16'h3333, 16'h4444,
                             16'h5555, 16'h6666, 16'h7777, 16'h8888};
    fdpc_regs i_fdpc_regs (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .cfg_rd_req_o(cfg_rd_req_o), .cfg_rd_addr_o(cfg_rd_addr_o),
        .cfg_rd_ack_i(cfg_rd_ack_i), .cfg_rd_data_i(cfg_rd_data_i),
        .cfg_rd_dbe_i(cfg_rd_dbe_i), .cfg_ready_o(cfg_ready_o), .cmd_start_o(cmd_start_o),
        .cmd_code_o(cmd_code_o), .cmd_addr_o(cmd_addr_o), .cmd_done_i(cmd_done_i),
        .cmd_res_we_i(cmd_res_we_i), .cmd_res_idx_i(cmd_res_idx_i),
        .cmd_res_data_i(cmd_res_data_i), .prot_o(prot_o), .option_o(option_o));
    initial begin
        clk_i = 1'b0;
        forever #4 clk_i = ~clk_i;
    end
    // a hang is counted as a failure and still reaches the verdict
    always @(posedge clk_i) begin
        cycles++;
        if (cmd_start_o === 1'b1) begin
            starts++;
        end
        if (cycles == 5000) begin
            err_count++;
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // request held until ack is sampled high, released on that same edge
    task automatic wb(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                      input logic [31:0] dat);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_sel_i <= sel;
        wb_dat_i <= dat;
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        rdv = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb
    task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] mask,
                         input logic [31:0] exp);
        wb(1'b0, adr, 4'h3, 32'h0);
        chk(what, rdv & mask, exp);
    endtask : rdchk
    // array side: answer one fetch, then scramble the released data lines
    task automatic cfg_ans(input logic [17:0] adr, input logic [7:0] dat, input logic dbe);
        do @(posedge clk_i); while (cfg_rd_req_o !== 1'b1);
        chk("cfg_addr", cfg_rd_addr_o, adr);
        cfg_rd_ack_i <= 1'b1;
        cfg_rd_data_i <= dat;
        cfg_rd_dbe_i <= dbe;
        @(posedge clk_i);
        cfg_rd_ack_i <= 1'b0;
        cfg_rd_dbe_i <= 1'b0;
        cfg_rd_data_i <= ~dat;
        do @(posedge clk_i); while (cfg_rd_req_o === 1'b1);
    endtask : cfg_ans
    task automatic run_cmd(input logic [7:0] code, input logic [17:0] adr);
        wb(1'b1, OFF_CIDX, 4'h1, 32'h0);
        wb(1'b1, OFF_CWORD, 4'h3, {16'h0, code, 6'h0, adr[17:16]});
        wb(1'b1, OFF_CIDX, 4'h1, 32'h1);
        wb(1'b1, OFF_CWORD, 4'h3, {16'h0, adr[15:0]});
        wb(1'b1, OFF_STAT, 4'h1, 32'h80);
        repeat (3) @(posedge clk_i);
    endtask : run_cmd
    task automatic done_pulse();
        cmd_done_i <= 1'b1;
        @(posedge clk_i);
        cmd_done_i <= 1'b0;
        @(posedge clk_i);
    endtask : done_pulse
    task automatic t_boot();
        cfg_ans(CFG_DPROT_ADDR, 8'hf3, 1'b0);
        cfg_ans(CFG_OPT_ADDR, 8'h5a, 1'b0);
        do @(posedge clk_i); while (cfg_ready_o !== 1'b1);
        rdchk("ready", OFF_CFG, 32'h2, 32'h2);
        chk("prot_boot", prot_o, 8'h83);
        chk("opt_boot", option_o, 8'h5a);
        wb(1'b1, OFF_OPT, 4'h1, 32'h0);
        rdchk("opt_ro", OFF_OPT, 32'hff, 32'h5a);
        $display("test boot done");
    endtask : t_boot
    task automatic t_prot();
        int s0;
        logic [7:0] wv [6] = '{8'h85, 8'h02, 8'h01, 8'h82, 8'h72, 8'h75};
        logic [7:0] ev [6] = '{8'h85, 8'h02, 8'h02, 8'h02, 8'h02, 8'h05};
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, OFF_DPROT, 4'h1, {24'h0, wv[i]});
            rdchk("prot_rd", OFF_DPROT, 32'hff, {24'h0, ev[i]});
            if (i == 0) begin
                // open: size ignored, base address must be accepted
                s0 = starts;
                run_cmd(CMD_PROG_DF, DF_BASE);
                chk("open_start", starts, s0 + 1);
                rdchk("open_viol", OFF_STAT, 32'h10, 32'h0);
                done_pulse();
            end
        end
        chk("prot_o", prot_o, 8'h05);
        $display("test prot done");
    endtask : t_prot
    task automatic t_cobj();
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, OFF_CIDX, 4'h1, i);
            wb(1'b1, OFF_CWORD, 4'h3, {16'h0, pat[i]});
        end
        for (int i = 0; i < 8; i++) begin
            wb(1'b1, OFF_CIDX, 4'h1, i);
            rdchk("cobj", OFF_CWORD, 32'hffff, (i < 6) ? {16'h0, pat[i]} : 32'h0);
        end
        chk("code", cmd_code_o, 8'h11);
        chk("addr", cmd_addr_o, 18'h12222);
        wb(1'b1, OFF_CIDX, 4'h1, 32'h2);
        wb(1'b1, OFF_CWORD, 4'h1, 32'h00ab);
        rdchk("lo_byte", OFF_CWORD, 32'hffff, 32'h33ab);
        wb(1'b1, OFF_CWORD, 4'h2, 32'hcd00);
        rdchk("hi_byte", OFF_CWORD, 32'hffff, 32'hcdab);
        $display("test cobj done");
    endtask : t_cobj
    task automatic t_lock();
        int s0 = starts;
        run_cmd(CMD_PROG_DF, 18'h04a00);
        chk("start", starts, s0 + 1);
        rdchk("busy", OFF_STAT, 32'h90, 32'h0);
        wb(1'b1, OFF_CWORD, 4'h3, 32'hffff);
        chk("locked", cmd_addr_o, 18'h04a00);
        cmd_res_we_i <= 1'b1;
        cmd_res_idx_i <= 3'h3;
        cmd_res_data_i <= 16'hbeef;
        @(posedge clk_i);
        cmd_res_we_i <= 1'b0;
        done_pulse();
        rdchk("done", OFF_STAT, 32'h80, 32'h80);
        wb(1'b1, OFF_CIDX, 4'h1, 32'h3);
        rdchk("result", OFF_CWORD, 32'hffff, 32'hbeef);
        $display("test lock done");
    endtask : t_lock
    task automatic t_viol();
        int s0;
        logic [7:0] cd [3] = '{CMD_PROG_DF, CMD_ERASE_DF_SECT, CMD_ERASE_BLOCK};
        logic [17:0] ad [3] = '{18'h049ff, DF_BASE, 18'h05300};
        for (int i = 0; i < 3; i++) begin
            s0 = starts;
            run_cmd(cd[i], ad[i]);
            chk("refused", starts, s0);
            rdchk("viol", OFF_STAT, 32'h90, 32'h90);
            wb(1'b1, OFF_STAT, 4'h1, 32'h10);
        end
        $display("test viol done");
    endtask : t_viol
    task automatic t_rsv();
        for (int a = OFF_RSV1; a <= OFF_RSV4; a += 4) begin
            wb(1'b1, a[7:0], 4'h3, 32'hffff);
            rdchk("rsv", a[7:0], 32'hffffffff, 32'h0);
        end
        rdchk("unmapped", 8'h40, 32'hffffffff, 32'h0);
        $display("test rsv done");
    endtask : t_rsv
    task automatic t_reload();
        int s0;
        wb(1'b1, OFF_CFG, 4'h1, 32'h1);
        cfg_ans(CFG_DPROT_ADDR, 8'h80, 1'b1);
        cfg_ans(CFG_OPT_ADDR, 8'h3c, 1'b1);
        do @(posedge clk_i); while (cfg_ready_o !== 1'b1);
        chk("prot_fault", prot_o, DP_FAULT_VALUE);
        chk("opt_fault", option_o, OPT_FAULT_VALUE);
        // full protection must still reach the last data flash byte
        s0 = starts;
        run_cmd(CMD_PROG_DF, DF_END);
        chk("top_refused", starts, s0);
        rdchk("top_viol", OFF_STAT, 32'h90, 32'h90);
        $display("test reload done");
    endtask : t_reload
    initial begin
        rst_i = 1'b1;
        wb_cyc_i = 1'b0;
        wb_stb_i = 1'b0;
        wb_we_i = 1'b0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        cfg_rd_ack_i = 1'b0;
        cfg_rd_data_i = 8'h0;
        cfg_rd_dbe_i = 1'b0;
        cmd_done_i = 1'b0;
        cmd_res_we_i = 1'b0;
        cmd_res_idx_i = 3'h0;
        cmd_res_data_i = 16'h0;
        repeat (5) @(posedge clk_i);
        chk("prot_rst", prot_o, 8'h0f);
        rst_i <= 1'b0;
        t_boot();
        t_prot();
        t_cobj();
        t_lock();
        t_viol();
        t_rsv();
        t_reload();
        end_sim();
    end
endmodule : fdpc_regs_bench
`default_nettype wire
